// ===== logic/pfg_pkg.sv
`default_nettype none
package pfg_pkg;
   // ==========================================================
   // Sizes
   localparam int NGEN = 4;
   localparam int NFLT = 4;
   localparam int NDC = 8;
   localparam int NEV = 6;
   localparam int PW = 16;

   // ==========================================================
   // Per-generator register offsets (generator in paddr[7:6])
   localparam logic [5:0] OFS_CTL = 6'h00;
   localparam logic [5:0] OFS_INTEN = 6'h04;
   localparam logic [5:0] OFS_RIS = 6'h08;
   localparam logic [5:0] OFS_ISC = 6'h0C;
   localparam logic [5:0] OFS_LOAD = 6'h10;
   localparam logic [5:0] OFS_FSENSE = 6'h14;
   localparam logic [5:0] OFS_MINFLT = 6'h18;
   localparam logic [5:0] OFS_FSRC0 = 6'h1C;
   localparam logic [5:0] OFS_FSRC1 = 6'h20;
   localparam logic [5:0] OFS_FSTAT0 = 6'h24;
   localparam logic [5:0] OFS_FSTAT1 = 6'h28;
   // Module-level registers
   localparam logic [8:0] OFS_MIEN = 9'h100;
   localparam logic [8:0] OFS_MSTAT = 9'h104;

   // ==========================================================
   // Field positions
   localparam int CTL_RUN_BIT = 0;
   localparam int CTL_EXT_BIT = 1;
   localparam int CTL_MINP_BIT = 2;
   localparam int CTL_LATCH_BIT = 3;
   localparam int INTEN_TRG_LSB = 8;
   // Event order: zero, load, cmpa up, cmpa down, cmpb up, cmpb down
   localparam int EV_ZERO = 0;
   localparam int EV_LOAD = 1;

   // ==========================================================
   // Per-generator configuration
   typedef struct packed {
      logic run;
      logic extended_fault_source_en;
      logic fault_min_duration_mode;
      logic latched;
      logic [NEV-1:0] irq_en;
      logic [NEV-1:0] trig_en;
      logic [NFLT-1:0] sense_low;
      logic [NFLT-1:0] src0;
      logic [NDC-1:0] src1;
      logic [PW-1:0] period;
      logic [PW-1:0] min_per;
   } pfg_cfg_t;

   localparam pfg_cfg_t CFG_RST = '0;
   localparam logic [NGEN-1:0] MIEN_RST = 4'h0;
endpackage
`default_nettype wire

// ===== logic/pfg_fault_irq.sv
`default_nettype none
// Notes on behaviour
// - Legacy mode uses external fault zero only
// - Extended mode uses per-generator selection masks
// - Fault is OR of selected sources
// - Polarity adjust each external input first
// - Two masks: four inputs, eight comparators
// - Both masks read back per generator
// - Write one clears status, zero keeps
// - Six counter event interrupt sources
// - Enable register holds interrupt and trigger bits
// - Cleared enable bit masks that source
// - Raw and masked status separately readable
// - Line needs source and module enable
// - Period is ticks between zero pulses
// - Period reads last programmed value
// - Per-input polarity setting per generator
// - Minimum fault duration stretches fault signal
// - Latched mode holds trigger status bits
module pfg_fault_irq
   import pfg_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [8:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic pready_o,
   output logic [31:0] prdata_o,
   output logic pslverr_o,
   // Fault and comparator sources
   input wire logic [NFLT-1:0] ext_fault_input_i,
   input wire logic [NGEN-1:0][NDC-1:0] dig_comparator_trig_i,
   input wire logic [NGEN-1:0][3:0] cmp_evt_i,
   // Results
   output wire logic [NGEN-1:0] fault_o,
   output wire logic [NGEN-1:0][NEV-1:0] trig_o,
   output wire logic [NGEN-1:0] irq_gen_o,
   output logic irq_o
);

   // ==========================================================
   // Fault pin synchroniser

   logic [NFLT-1:0] flt_meta;
   logic [NFLT-1:0] flt_sync;

   // Pins are asynchronous to the PWM clock
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         flt_meta <= '0;
         flt_sync <= '0;
      end else begin
         flt_meta <= ext_fault_input_i;
         flt_sync <= flt_meta;
      end
   end

   // ==========================================================
   // APB decode

   logic apb_acc;
   logic apb_done;
   logic wr_en;
   logic mod_sel;
   logic [1:0] gsel;
   logic [5:0] gofs;
   logic addr_ok;
   logic [31:0] rd_data;
   logic [31:0] rd_gen [NGEN];
   logic [NGEN-1:0] mien;
   logic [NGEN-1:0] gen_line;

   // Address split and legality
   assign apb_acc = psel_i & penable_i;
   assign apb_done = apb_acc & pready_o;
   assign wr_en = apb_done & pwrite_i;
   assign mod_sel = paddr_i[8];
   assign gsel = paddr_i[7:6];
   assign gofs = paddr_i[5:0];
   assign addr_ok = mod_sel ? (paddr_i == OFS_MIEN || paddr_i == OFS_MSTAT)
                            : (gofs[1:0] == 2'h0 && gofs <= OFS_FSTAT1);

   // Read selection; unmapped reads as zero
   assign rd_data = !addr_ok ? 32'h0000_0000 :
                    (paddr_i == OFS_MIEN) ? {28'h000_0000, mien} :
                    mod_sel ? {28'h000_0000, irq_gen_o} :
                    rd_gen[gsel];

   // One wait state: data is captured so prdata comes from a flop
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         pready_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= apb_acc & ~pready_o;
         if (apb_acc & ~pready_o) begin
            prdata_o <= rd_data;
            pslverr_o <= ~addr_ok;
         end
      end
   end

   // Module-level generator interrupt enables
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         mien <= MIEN_RST;
      end else if (wr_en && paddr_i == OFS_MIEN) begin
         mien <= pwdata_i[NGEN-1:0];
      end
   end

   // Combined line; generator lines are already registered
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |gen_line;
      end
   end

   // ==========================================================
   // Generators

   genvar g;
   generate
      for (g = 0; g < NGEN; g++) begin : gen_blk
         pfg_cfg_t cfg;
         logic wr_g;
         logic [PW-1:0] cnt;
         logic [PW-1:0] per_act;
         logic [PW-1:0] reload;
         logic [PW-1:0] min_cnt;
         logic [NEV-1:0] ev;
         logic [NEV-1:0] ris;
         logic [NEV-1:0] ris_clr;
         logic [NEV-1:0] masked;
         logic [NFLT-1:0] sensed;
         logic [NFLT-1:0] fstat0;
         logic [NDC-1:0] fstat1;
         logic [NFLT-1:0] fclr0;
         logic [NDC-1:0] fclr1;
         logic flt_raw;
         logic flt_q;
         logic line_q;
         logic [NEV-1:0] trig_q;

         // Register write strobes for this generator
         assign wr_g = wr_en & ~mod_sel & (gsel == 2'(g));
         assign ris_clr = (wr_g && gofs == OFS_ISC) ? pwdata_i[NEV-1:0] : '0;
         assign fclr0 = (wr_g && gofs == OFS_FSTAT0) ? pwdata_i[NFLT-1:0] : '0;
         assign fclr1 = (wr_g && gofs == OFS_FSTAT1) ? pwdata_i[NDC-1:0] : '0;

         // Configuration registers
         always_ff @(posedge clk_sys_i) begin
            if (srst_i) begin
               cfg <= CFG_RST;
            end else if (wr_g) begin
               case (gofs)
                  OFS_CTL: begin
                     cfg.run <= pwdata_i[CTL_RUN_BIT];
                     cfg.extended_fault_source_en <= pwdata_i[CTL_EXT_BIT];
                     cfg.fault_min_duration_mode <= pwdata_i[CTL_MINP_BIT];
                     cfg.latched <= pwdata_i[CTL_LATCH_BIT];
                  end
                  OFS_INTEN: begin
                     cfg.irq_en <= pwdata_i[NEV-1:0];
                     cfg.trig_en <= pwdata_i[INTEN_TRG_LSB +: NEV];
                  end
                  OFS_LOAD: cfg.period <= pwdata_i[PW-1:0];
                  OFS_FSENSE: cfg.sense_low <= pwdata_i[NFLT-1:0];
                  OFS_MINFLT: cfg.min_per <= pwdata_i[PW-1:0];
                  OFS_FSRC0: cfg.src0 <= pwdata_i[NFLT-1:0];
                  OFS_FSRC1: cfg.src1 <= pwdata_i[NDC-1:0];
                  default: ;
               endcase
            end
         end

         // Read view; period shows the programmed, not active, value
         assign rd_gen[g] =
            (gofs == OFS_CTL) ? {28'h000_0000, cfg.latched, cfg.fault_min_duration_mode,
                                 cfg.extended_fault_source_en, cfg.run} :
            (gofs == OFS_INTEN) ? {18'h0_0000, cfg.trig_en, 2'h0, cfg.irq_en} :
            (gofs == OFS_RIS) ? {26'h000_0000, ris} :
            (gofs == OFS_ISC) ? {26'h000_0000, masked} :
            (gofs == OFS_LOAD) ? {16'h0000, cfg.period} :
            (gofs == OFS_FSENSE) ? {28'h000_0000, cfg.sense_low} :
            (gofs == OFS_MINFLT) ? {16'h0000, cfg.min_per} :
            (gofs == OFS_FSRC0) ? {28'h000_0000, cfg.src0} :
            (gofs == OFS_FSRC1) ? {24'h00_0000, cfg.src1} :
            (gofs == OFS_FSTAT0) ? {28'h000_0000, fstat0} :
            (gofs == OFS_FSTAT1) ? {24'h00_0000, fstat1} :
            32'h0000_0000;

         // ----------------------------------------------------
         // Counter: down count, period of zero treated as one
         assign reload = (cfg.period == 16'h0000) ? 16'h0000 : cfg.period - 16'h0001;

         // Events: zero, load, then the four comparator matches
         assign ev[EV_ZERO] = cfg.run & (cnt == 16'h0000);
         assign ev[EV_LOAD] = cfg.run & (per_act != 16'h0000) &
                              (cnt == per_act - 16'h0001);
         assign ev[NEV-1:2] = cmp_evt_i[g];

         // Pending period only lands at zero, avoiding runt pulses
         always_ff @(posedge clk_sys_i) begin
            if (srst_i) begin
               cnt <= 16'h0000;
               per_act <= 16'h0000;
            end else if (!cfg.run) begin
               cnt <= 16'h0000;
               per_act <= cfg.period;
            end else if (cnt == 16'h0000) begin
               cnt <= reload;
               per_act <= cfg.period;
            end else begin
               cnt <= cnt - 16'h0001;
            end
         end

         // ----------------------------------------------------
         // Interrupt status; set wins over a same-cycle clear
         always_ff @(posedge clk_sys_i) begin
            if (srst_i) begin
               ris <= '0;
            end else begin
               ris <= (ris & ~ris_clr) | ev;
            end
         end

         assign masked = ris & cfg.irq_en;

         // Generator line and converter triggers
         always_ff @(posedge clk_sys_i) begin
            if (srst_i) begin
               line_q <= 1'b0;
               trig_q <= '0;
            end else begin
               line_q <= (|masked) & mien[g];
               trig_q <= ev & cfg.trig_en;
            end
         end

         assign irq_gen_o[g] = line_q;
         assign gen_line[g] = line_q;
         assign trig_o[g] = trig_q;

         // ----------------------------------------------------
         // Fault combination
         assign sensed = flt_sync ^ cfg.sense_low;
         assign flt_raw = cfg.extended_fault_source_en ?
                          ((|(sensed & cfg.src0)) |
                           (|(dig_comparator_trig_i[g] & cfg.src1))) :
                          sensed[0];

         // Minimum duration timer restarts while the fault is present
         always_ff @(posedge clk_sys_i) begin
            if (srst_i) begin
               min_cnt <= 16'h0000;
               flt_q <= 1'b0;
            end else begin
               if (flt_raw && cfg.fault_min_duration_mode) begin
                  min_cnt <= cfg.min_per;
               end else if (min_cnt != 16'h0000) begin
                  min_cnt <= min_cnt - 16'h0001;
               end
               flt_q <= flt_raw | (cfg.fault_min_duration_mode &
                                   (min_cnt > 16'h0001));
            end
         end

         assign fault_o[g] = flt_q;

         // Trigger status: live, or sticky until cleared when latched
         always_ff @(posedge clk_sys_i) begin
            if (srst_i) begin
               fstat0 <= '0;
               fstat1 <= '0;
            end else if (cfg.latched) begin
               fstat0 <= (fstat0 & ~fclr0) | sensed;
               fstat1 <= (fstat1 & ~fclr1) | dig_comparator_trig_i[g];
            end else begin
               fstat0 <= sensed;
               fstat1 <= dig_comparator_trig_i[g];
            end
         end
      end
   endgenerate

endmodule // pfg_fault_irq
`default_nettype wire

// ===== testbench/pfg_fault_irq_chk.sv
`default_nettype none
// ==========================================
// Port-level checker
module pfg_fault_irq_chk
   import pfg_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [8:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic pready_o,
   input wire logic [31:0] prdata_o,
   input wire logic pslverr_o,
   input wire logic [NFLT-1:0] ext_fault_input_i,
   input wire logic [NGEN-1:0][NDC-1:0] dig_comparator_trig_i,
   input wire logic [NGEN-1:0][3:0] cmp_evt_i,
   input wire logic [NGEN-1:0] fault_o,
   input wire logic [NGEN-1:0][NEV-1:0] trig_o,
   input wire logic [NGEN-1:0] irq_gen_o,
   input wire logic irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   // Bus steps: setup, then one wait state
   sequence s_setup; psel_i && !penable_i; endsequence
   sequence s_wait; psel_i && penable_i && !pready_o; endsequence
   chk_ready_wait: assert property (s_setup |=> s_wait ##1 pready_o) else $error("ready late");
   chk_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready held");
   chk_err_unmapped: assert property (pready_o && paddr_i[8] && paddr_i[7:0] > 8'h04
      |-> pslverr_o) else $error("no error on hole");
   chk_ok_mapped: assert property (pready_o && !paddr_i[8] && paddr_i[5:0] <= 6'h28
      && paddr_i[1:0] == 2'h0 |-> !pslverr_o) else $error("error on register");
   chk_err_read: assert property (pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
      else $error("hole read not zero");
   chk_load_upper: assert property (pready_o && !pwrite_i && !paddr_i[8]
      && paddr_i[5:0] == OFS_LOAD |-> prdata_o[31:16] == 16'h0) else $error("upper bits");
   chk_irq_or: assert property (!$past(srst_i) |-> irq_o == $past(|irq_gen_o))
      else $error("irq line");
   chk_reset_quiet: assert property ($fell(srst_i) |-> !pready_o && fault_o == '0
      && trig_o == '0 && irq_gen_o == '0 && !irq_o) else $error("outputs after reset");
   // Compare triggers only follow an input pulse
   for (genvar g = 0; g < NGEN; g++) begin : g_trig
      chk_trig_cause: assert property ((trig_o[g][5:2] & ~$past(cmp_evt_i[g])) == 4'h0)
         else $error("trigger without event");
   end
endmodule // pfg_fault_irq_chk
bind pfg_fault_irq pfg_fault_irq_chk u_chk (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
   .ext_fault_input_i(ext_fault_input_i), .dig_comparator_trig_i(dig_comparator_trig_i),
   .cmp_evt_i(cmp_evt_i), .fault_o(fault_o), .trig_o(trig_o), .irq_gen_o(irq_gen_o),
   .irq_o(irq_o));
`default_nettype wire

// ===== testbench/pfg_src_model.sv
`default_nettype none
// ==========================================
// Fault pins, comparators and compare events
module pfg_src_model
   import pfg_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic [NFLT-1:0] pin_lvl_i,
   input wire logic [NGEN-1:0][NDC-1:0] dcmp_lvl_i,
   input wire logic [NGEN-1:0][3:0] evt_req_i,
   output var logic [NFLT-1:0] ext_fault_input_o = '0,
   output var logic [NGEN-1:0][NDC-1:0] dig_comparator_trig_o = '0,
   output var logic [NGEN-1:0][3:0] cmp_evt_o = '0
);
   timeunit 1ns;
   timeprecision 1ps;
   // Sources move just after the edge, like real comparators
   always @(posedge clk_sys_i) begin
      ext_fault_input_o <= pin_lvl_i;
      dig_comparator_trig_o <= dcmp_lvl_i;
      cmp_evt_o <= evt_req_i;
   end
endmodule // pfg_src_model
`default_nettype wire

// ===== testbench/tb_top.sv
`default_nettype none
// ==========================================
// Top-level bench
module tb_top
   import pfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 0, srst_i = 1, psel = 0, penable = 0, pwrite = 0, pready, er, irq, perr;
   logic [8:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [3:0] pins = '0, ext;
   logic [NGEN-1:0][NDC-1:0] dc = '0, dct;
   logic [NGEN-1:0][3:0] evq = '0, cev, sn, s0;
   logic [NGEN-1:0][7:0] s1;
   logic [NGEN-1:0] flt, irqg;
   logic [NGEN-1:0][NEV-1:0] trg;
   logic [5:0] tseen = '0;
   int fails = 0, compares = 0, n;
   pfg_src_model u_src (.clk_sys_i(clk_sys_i), .pin_lvl_i(pins), .dcmp_lvl_i(dc),
      .evt_req_i(evq), .ext_fault_input_o(ext), .dig_comparator_trig_o(dct), .cmp_evt_o(cev));
   pfg_fault_irq uut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .pready_o(pready), .prdata_o(prdata), .pslverr_o(perr), .ext_fault_input_i(ext),
      .dig_comparator_trig_i(dct), .cmp_evt_i(cev), .fault_o(flt), .trig_o(trg),
      .irq_gen_o(irqg), .irq_o(irq));
   // 125 MHz clock
   initial forever #4 clk_sys_i = ~clk_sys_i;
   // ==========================================
   // Helpers
   function automatic logic [8:0] ga(int g, logic [5:0] o);
      ga = {1'b0, 2'(g), o};
   endfunction
   // Expected fault: sense first, then legacy pin or selected OR
   function automatic logic fexp(logic x, logic [3:0] se, m0, p, logic [7:0] m1, d);
      logic [3:0] a;
      a = p ^ se;
      fexp = x ? (|(a & m0) || |(d & m1)) : a[0];
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Request held until ready is sampled high
   task automatic apb(input logic w, input logic [8:0] a, input logic [31:0] d);
      @(posedge clk_sys_i) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk_sys_i) penable <= 1'b1;
      do @(posedge clk_sys_i); while (pready !== 1'b1);
      rd = prdata;
      er = perr;
      {psel, penable} <= 2'b00;
   endtask
   // Pulse all compare events of generator one, collect its trigger pulses
   task automatic evp();
      tseen = '0;
      @(posedge clk_sys_i) evq[1] <= 4'hF;
      @(posedge clk_sys_i) evq[1] <= 4'h0;
      repeat (4) begin
         @(posedge clk_sys_i);
         #1 tseen = tseen | trg[1];
      end
   endtask
   task automatic ppulse(input logic [3:0] m, input int w);
      @(posedge clk_sys_i) pins <= m;
      @(posedge clk_sys_i) pins <= 4'h0;
      repeat (w) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic complete_run;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Hang guard, well beyond the planned run
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      fails++;
      complete_run();
   end
   // ==========================================
   // Main sequence
   initial begin
      n = $urandom(32'h148FAEA3);
      repeat (5) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      for (int g = 0; g < NGEN; g++) begin
         {sn[g], s0[g], s1[g]} = 16'($urandom);
         apb(1, ga(g, OFS_FSRC0), 32'(s0[g]));
         apb(1, ga(g, OFS_FSRC1), 32'(s1[g]));
         apb(1, ga(g, OFS_FSENSE), 32'(sn[g]));
         apb(1, ga(g, OFS_CTL), 32'(g[0]) << CTL_EXT_BIT);
         apb(0, ga(g, OFS_FSRC0), 0);
         chk("src0", rd, 32'(s0[g]));
         apb(0, ga(g, OFS_FSRC1), 0);
         chk("src1", rd, 32'(s1[g]));
      end
      apb(0, 9'h1FC, 0);
      chk("hole", 32'(er), 1);
      $display("test masks done");
      repeat (16) begin
         @(posedge clk_sys_i) {pins, dc} <= 36'({$urandom, $urandom});
         repeat (6) @(posedge clk_sys_i);
         #1;
         for (int g = 0; g < NGEN; g++)
            chk("fault", 32'(flt[g]), 32'(fexp(g[0], sn[g], s0[g], pins, s1[g], dc[g])));
      end
      @(posedge clk_sys_i) pins <= 4'h0;
      $display("test fault select done");
      apb(1, ga(1, OFS_INTEN), 32'h00003C0C);
      evp();
      chk("trig", 32'(tseen), 32'h3C);
      apb(0, ga(1, OFS_RIS), 0);
      chk("raw", rd, 32'h3C);
      apb(0, ga(1, OFS_ISC), 0);
      chk("masked", rd, 32'h0C);
      chk("irqgen", 32'(irqg), 0);
      apb(1, OFS_MIEN, 32'h2);
      repeat (3) @(posedge clk_sys_i);
      #1;
      chk("irqgen", 32'(irqg), 32'h2);
      chk("irq", 32'(irq), 1);
      apb(1, ga(1, OFS_ISC), 0);
      apb(0, ga(1, OFS_RIS), 0);
      chk("keep", rd, 32'h3C);
      apb(1, ga(1, OFS_ISC), 32'h3C);
      apb(0, ga(1, OFS_RIS), 0);
      chk("clear", rd, 0);
      apb(1, ga(1, OFS_INTEN), 32'h0000000C);
      evp();
      chk("trigoff", 32'(tseen), 0);
      $display("test interrupts done");
      apb(1, ga(2, OFS_LOAD), 32'd5);
      apb(1, ga(2, OFS_INTEN), 32'h100);
      apb(1, ga(2, OFS_CTL), 32'h1);
      repeat (3) @(posedge clk_sys_i iff trg[2][0] === 1'b1);
      n = 0;
      do begin @(posedge clk_sys_i); n++; end while (trg[2][0] !== 1'b1);
      chk("period", 32'(n), 5);
      apb(1, ga(2, OFS_LOAD), 32'd9);
      apb(0, ga(2, OFS_LOAD), 0);
      chk("load", rd, 9);
      $display("test period done");
      apb(1, ga(3, OFS_FSENSE), 0);
      apb(1, ga(3, OFS_MINFLT), 32'd12);
      apb(1, ga(3, OFS_CTL), 32'h4);
      ppulse(4'h1, 10);
      chk("minhold", 32'(flt[3]), 1);
      repeat (20) @(posedge clk_sys_i);
      #1;
      chk("minend", 32'(flt[3]), 0);
      apb(1, ga(3, OFS_CTL), 32'h8);
      ppulse(4'h4, 8);
      apb(0, ga(3, OFS_FSTAT0), 0);
      chk("latched", rd & 32'h4, 32'h4);
      apb(1, ga(3, OFS_FSTAT0), 32'h4);
      apb(0, ga(3, OFS_FSTAT0), 0);
      chk("unlatch", rd & 32'h4, 0);
      // Unlatched status follows the pin level both ways
      @(posedge clk_sys_i) pins <= 4'h2;
      apb(1, ga(3, OFS_CTL), 0);
      apb(0, ga(3, OFS_FSTAT0), 0);
      chk("live", rd, 32'h2);
      @(posedge clk_sys_i) pins <= 4'h0;
      repeat (4) @(posedge clk_sys_i);
      apb(0, ga(3, OFS_FSTAT0), 0);
      chk("livedrop", rd, 0);
      $display("test fault timing done");
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
